// ===== common/pbs_pkg.sv
// Package for the pipelined burst memory port: widths, reset values, types.
// Assumes a single synchronous clock domain and no software-visible registers.
package pbs_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int ADDR_W_DEF  = 20;
   localparam int DATA_W_DEF  = 16;
   localparam int LANES_DEF   = 2;
   localparam int BURST_W     = 2;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [1:0] BURST_CNT_RST = 2'h0;
   localparam logic       MODE_RST      = 1'h1;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic {
      PBS_LINEAR,
      PBS_INTERLEAVED
   } pbs_order_e;

   typedef enum logic [1:0] {
      PBS_IDLE,
      PBS_READ,
      PBS_WRITE
   } pbs_state_e;

   // Synchronous control pins, all sampled on the rising clock edge
   typedef struct packed {
      logic chip_sel1_n;
      logic chip_sel2;
      logic chip_sel3_n;
      logic cpu_addr_strobe_n;
      logic ctrl_addr_strobe_n;
      logic burst_step_n;
      logic all_byte_write_n;
      logic byte_write_gate_n;
   } pbs_ctl_s;

endpackage : pbs_pkg

// ===== logic/pbs_port.sv
// Pipelined burst static memory: address, burst, write and read pipeline.
// Assumes all synchronous inputs are stable around the rising edge of ref_clk_i.
`timescale 1ns/1ps

module pbs_port
   import pbs_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int DATA_W = DATA_W_DEF,
   parameter int LANES  = LANES_DEF
) (
   input  wire logic              ref_clk_i,
   input  wire logic              resetn_i,
   input  wire logic              clk_en_i,
   input  wire pbs_ctl_s          ctl_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [LANES-1:0]  byte_lane_sel_n_i,
   input  wire logic              out_en_n_i,
   input  wire logic              sleep_req_i,
   input  wire logic              burst_mode_i,
   input  wire logic [DATA_W-1:0] data_in_i,
   input  wire logic [LANES-1:0]  parity_lines_in_i,
   output logic [DATA_W-1:0]      data_o,
   output logic [LANES-1:0]       parity_lines_o,
   output logic                   data_oe_o
);

   localparam int LANE_W = DATA_W / LANES;
   localparam int WORD_W = DATA_W + LANES;
   localparam int DEPTH  = 1 << ADDR_W;

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   logic [WORD_W-1:0] mem [DEPTH];

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   pbs_state_e              state_reg,   state_next;
   logic [ADDR_W-1:0]       addr_reg,    addr_next;
   logic [BURST_W-1:0]      cnt_reg,     cnt_next;
   pbs_order_e              order_reg,   order_next;
   logic                    strap_reg,   strap_next;
   logic                    mask_reg,    mask_next;
   logic [DATA_W-1:0]       dout_reg,    dout_next;
   logic [LANES-1:0]        pout_reg,    pout_next;

   logic                    sel;
   logic                    cpu_go;
   logic                    ctrl_go;
   logic                    any_write;
   logic                    access;
   logic                    do_write;
   logic [ADDR_W-1:0]       acc_addr;
   logic [BURST_W-1:0]      start_bits;
   logic [BURST_W-1:0]      burst_low;
   logic [LANES-1:0]        lane_we;
   logic                    run;

   // ------------------------------------------------------------------
   // Decode of sampled controls
   // ------------------------------------------------------------------
   assign run     = clk_en_i & ~sleep_req_i;
   assign sel     = ~ctl_i.chip_sel1_n & ctl_i.chip_sel2 & ~ctl_i.chip_sel3_n;
   assign cpu_go  = ~ctl_i.cpu_addr_strobe_n & ~ctl_i.chip_sel1_n;
   assign ctrl_go = ~ctl_i.ctrl_addr_strobe_n & ~cpu_go;

   // Lane write enables
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign lane_we[g] = ~ctl_i.all_byte_write_n
                        | (~ctl_i.byte_write_gate_n & ~byte_lane_sel_n_i[g]);
   end
   assign any_write = |lane_we;

   // Burst address generation
   assign start_bits = addr_reg[BURST_W-1:0];
   always_comb begin
      if (order_reg == PBS_INTERLEAVED) begin
         burst_low = start_bits ^ cnt_reg;
      end else begin
         burst_low = start_bits + cnt_reg;
      end
   end

   // ------------------------------------------------------------------
   // Access control
   // ------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      addr_next  = addr_reg;
      cnt_next   = cnt_reg;
      mask_next  = 1'b0;
      access     = 1'b0;
      do_write   = 1'b0;
      acc_addr   = {addr_reg[ADDR_W-1:BURST_W], burst_low};
      if (cpu_go) begin
         addr_next = addr_i;
         cnt_next  = BURST_CNT_RST;
         acc_addr  = addr_i;
         if (sel) begin
            access     = 1'b1;
            state_next = PBS_READ;
            mask_next  = (state_reg == PBS_IDLE);
         end else begin
            state_next = PBS_IDLE;
         end
      end else if (ctrl_go) begin
         addr_next = addr_i;
         cnt_next  = BURST_CNT_RST;
         acc_addr  = addr_i;
         if (sel) begin
            access     = 1'b1;
            do_write   = any_write;
            state_next = any_write ? PBS_WRITE : PBS_READ;
            mask_next  = ~any_write & (state_reg == PBS_IDLE);
         end else begin
            state_next = PBS_IDLE;
         end
      end else if (state_reg != PBS_IDLE) begin
         if (~ctl_i.burst_step_n) begin
            cnt_next = cnt_reg + 2'h1;
            acc_addr = {addr_reg[ADDR_W-1:BURST_W], cnt_next_low(cnt_reg)};
         end
         access     = 1'b1;
         do_write   = any_write;
         state_next = any_write ? PBS_WRITE : PBS_READ;
      end
   end

   function automatic logic [BURST_W-1:0] cnt_next_low(input logic [BURST_W-1:0] c);
      logic [BURST_W-1:0] n;
      n = c + 2'h1;
      if (order_reg == PBS_INTERLEAVED) begin
         cnt_next_low = start_bits ^ n;
      end else begin
         cnt_next_low = start_bits + n;
      end
   endfunction : cnt_next_low

   // Strap held static; caught on the first enabled edge after reset
   always_comb begin
      strap_next = 1'b1;
      order_next = order_reg;
      if (!strap_reg) begin
         order_next = burst_mode_i ? PBS_INTERLEAVED : PBS_LINEAR;
      end
   end

   // Read pipeline
   always_comb begin
      dout_next = dout_reg;
      pout_next = pout_reg;
      if (access && !do_write) begin
         {pout_next, dout_next} = mem[acc_addr];
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= PBS_IDLE;
         addr_reg  <= '0;
         cnt_reg   <= BURST_CNT_RST;
         order_reg <= pbs_order_e'(MODE_RST);
         strap_reg <= 1'b0;
         mask_reg  <= 1'b0;
         dout_reg  <= '0;
         pout_reg  <= '0;
      end else if (run) begin
         state_reg <= state_next;
         addr_reg  <= addr_next;
         cnt_reg   <= cnt_next;
         order_reg <= order_next;
         strap_reg <= strap_next;
         mask_reg  <= mask_next;
         dout_reg  <= dout_next;
         pout_reg  <= pout_next;
      end
   end

   // Memory write, per lane with its parity bit
   always_ff @(posedge ref_clk_i) begin
      if (run && do_write) begin
         for (int l = 0; l < LANES; l++) begin
            if (lane_we[l]) begin
               mem[acc_addr][l*LANE_W +: LANE_W] <= data_in_i[l*LANE_W +: LANE_W];
               mem[acc_addr][DATA_W + l]         <= parity_lines_in_i[l];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign data_o         = dout_reg;
   assign parity_lines_o = pout_reg;
   // Direction follows the output enable without waiting for the clock
   assign data_oe_o      = ~out_en_n_i & ~mask_reg & ~sleep_req_i
                           & (state_reg == PBS_READ);

endmodule : pbs_port

// ===== sim/pbs_port_asserts.sv
// Checker for the burst memory port, bound to every pbs_port.
// Assumes one clock domain and sees only the port's pins.
`timescale 1ns/1ps
module pbs_port_asserts
   import pbs_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF,
   parameter int LANES  = LANES_DEF
) (
   input  wire logic              ref_clk_i,
   input  wire logic              resetn_i,
   input  wire logic              clk_en_i,
   input  wire pbs_ctl_s          ctl_i,
   input  wire logic [LANES-1:0]  byte_lane_sel_n_i,
   input  wire logic              out_en_n_i,
   input  wire logic              sleep_req_i,
   input  wire logic [DATA_W-1:0] data_o,
   input  wire logic              data_oe_o
);
   // ---------------------------------------------
   // Decoded request kinds
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   logic run, sel, wr, cs, dsl, rds, rdc, oe_want, ign;
   assign run = clk_en_i & ~sleep_req_i;
   assign sel = ~ctl_i.chip_sel1_n & ctl_i.chip_sel2 & ~ctl_i.chip_sel3_n;
   assign wr  = ~ctl_i.all_byte_write_n | (~ctl_i.byte_write_gate_n & ~&byte_lane_sel_n_i);
   assign cs  = run & ~ctl_i.ctrl_addr_strobe_n & ctl_i.cpu_addr_strobe_n;
   assign dsl = cs & ~sel;
   assign rds = cs & sel & ~wr;
   assign rdc = run & ctl_i.ctrl_addr_strobe_n & ctl_i.cpu_addr_strobe_n & ~wr;
   assign oe_want = ~out_en_n_i & ~sleep_req_i;
   assign ign = run & ~ctl_i.cpu_addr_strobe_n & ctl_i.chip_sel1_n & ctl_i.ctrl_addr_strobe_n;
   AST_OE_LOW: assert property (data_oe_o |-> !out_en_n_i) else $error("drive without enable");
   AST_SLEEP_OFF: assert property (data_oe_o |-> !sleep_req_i) else $error("drive in sleep");
   AST_DESEL_OFF: assert property (dsl |=> !data_oe_o) else $error("drive after deselect");
   AST_FIRST_MASK: assert property (dsl ##1 rds |=> !data_oe_o) else $error("mask missing");
   AST_FOLLOW_OE: assert property (rds ##1 rdc |=> data_oe_o == oe_want)
      else $error("enable not followed");
   AST_HOLD_EN: assert property (!clk_en_i |=> $stable(data_o)) else $error("moved when off");
   AST_IGN_CPU: assert property (dsl ##1 ign |=> !data_oe_o)
      else $error("strobe not ignored");
   AST_WR_QUIET: assert property (cs & sel & wr |=> !data_oe_o) else $error("drive in write");
   AST_SLEEP_HOLD: assert property (sleep_req_i |=> $stable(data_o)) else $error("moved asleep");
   cover property (dsl ##1 rds);
   cover property (rds ##1 rdc ##1 rdc);
   cover property (!clk_en_i ##1 run);
endmodule : pbs_port_asserts

bind pbs_port pbs_port_asserts #(.DATA_W(DATA_W), .LANES(LANES)) chk_u (.ref_clk_i, .resetn_i,
   .clk_en_i, .ctl_i, .byte_lane_sel_n_i, .out_en_n_i, .sleep_req_i, .data_o, .data_oe_o);

// ===== sim/pbs_ctl_model.sv
// Controller model that drives the memory bus one cycle per call.
// Assumes the caller enters cyc just after a rising edge.
`timescale 1ns/1ps
module pbs_ctl_model
   import pbs_pkg::*;
(
   input  wire logic  ref_clk_i,
   output pbs_ctl_s   ctl_o,
   output logic [19:0] addr_o,
   output logic [15:0] wdata_o,
   output logic       out_en_n_o
);
   initial begin
      ctl_o = 8'h5f;
      addr_o = 20'h0;
      wdata_o = 16'h0;
      out_en_n_o = 1'b1;
   end
   task cyc(input pbs_ctl_s c, input logic [19:0] a, input logic [15:0] d);
      ctl_o = c;
      addr_o = a;
      out_en_n_o = ~(c.all_byte_write_n & c.byte_write_gate_n);
      wdata_o = out_en_n_o ? d : ~wdata_o;
      @(posedge ref_clk_i);
      #1;
   endtask : cyc
endmodule : pbs_ctl_model

// ===== sim/testbench.sv
// Bench for the burst memory port: table rows, then freeze, sleep, reset, order, lane write.
// Assumes the controller model drives control pins and write data.
`timescale 1ns/1ps
module testbench;
   import pbs_pkg::*;
   typedef struct packed {
      pbs_ctl_s    c;
      logic [19:0] a;
      logic [15:0] v;
      logic        k;
   } pbs_row_s;
   localparam pbs_row_s ROWS [15] = '{'{8'h55, 20'h12, 16'ha0a2, 1'b0},
      '{8'h59, 20'h0, 16'ha0a3, 1'b0}, '{8'h59, 20'h0, 16'ha0a0, 1'b0},
      '{8'h59, 20'h0, 16'ha0a1, 1'b0}, '{8'h17, 20'h0, 16'h0, 1'b0},
      '{8'h57, 20'h12, 16'ha0a2, 1'b1}, '{8'h5b, 20'h0, 16'ha0a3, 1'b1},
      '{8'h5b, 20'h0, 16'ha0a0, 1'b1}, '{8'h5b, 20'h0, 16'ha0a1, 1'b1},
      '{8'h5b, 20'h0, 16'ha0a2, 1'b1}, '{8'h45, 20'h11, 16'ha0a1, 1'b1},
      '{8'h4f, 20'h13, 16'ha0a3, 1'b1}, '{8'h57, 20'h11, 16'ha0a1, 1'b1},
      '{8'h17, 20'h0, 16'h0, 1'b0}, '{8'hcf, 20'h0, 16'ha0a1, 1'b1}};
   logic       clk = 0, rstn = 0, cen = 1, slp = 0, mode = 1;
   pbs_ctl_s   ctl;
   logic [19:0] addr;
   logic [15:0] wd, dq;
   logic [1:0] pq;
   logic [1:0] lanes = 2'h3;
   logic       oe_n, doe;
   int         miscompares = 0, compares = 0;
   always #12.5 clk = ~clk;
   pbs_ctl_model m_u (.ref_clk_i(clk), .ctl_o(ctl), .addr_o(addr), .wdata_o(wd),
      .out_en_n_o(oe_n));
   pbs_port dut_u (.ref_clk_i(clk), .resetn_i(rstn), .clk_en_i(cen), .ctl_i(ctl),
      .addr_i(addr), .byte_lane_sel_n_i(lanes), .out_en_n_i(oe_n), .sleep_req_i(slp),
      .burst_mode_i(mode), .data_in_i(wd), .parity_lines_in_i(wd[1:0]), .data_o(dq),
      .parity_lines_o(pq), .data_oe_o(doe));
   task chk(input logic [17:0] s, input logic [17:0] x);
      compares++;
      if (s !== x) begin
         miscompares++;
         $display("wrong value at %0t: saw %h want %h", $time, s, x);
      end
   endtask : chk
   task end_sim;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   initial begin
      #100us;
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (6) @(posedge clk);
      chk({pq, dq}, 18'h0);
      chk(18'(doe), 18'h0);
      #1 rstn = 1;
      foreach (ROWS[i]) begin
         m_u.cyc(ROWS[i].c, ROWS[i].a, ROWS[i].v);
         if (ROWS[i].k) chk({pq, dq}, {ROWS[i].v[1:0], ROWS[i].v});
      end
      $display("table done");
      cen = 0;
      m_u.cyc(8'h57, 20'h13, 16'h0);
      chk({pq, dq}, 18'h1a0a1);
      cen = 1;
      $display("freeze done");
      m_u.cyc(8'h57, 20'h12, 16'h0);
      chk(18'(doe), 18'h0);
      m_u.cyc(8'h5b, 20'h0, 16'h0);
      chk({pq, dq}, 18'h3a0a3);
      chk(18'(doe), 18'h1);
      slp = 1;
      m_u.cyc(8'h5b, 20'h0, 16'h0);
      chk({doe, pq, dq[14:0]}, {1'b0, 2'h3, 15'h20a3});
      slp = 0;
      $display("sleep done");
      rstn = 0;
      mode = 0;
      m_u.cyc(8'h5f, 20'h0, 16'h0);
      chk({pq, dq}, 18'h0);
      rstn = 1;
      m_u.cyc(8'h5f, 20'h0, 16'h0);
      m_u.cyc(8'h57, 20'h11, 16'h0);
      m_u.cyc(8'h5b, 20'h0, 16'h0);
      chk({pq, dq}, 18'h2a0a2);
      m_u.cyc(8'h5b, 20'h0, 16'h0);
      chk({pq, dq}, 18'h3a0a3);
      m_u.cyc(8'hcb, 20'h0, 16'h0);
      chk({pq, dq}, 18'h0a0a0);
      chk(18'(doe), 18'h1);
      $display("linear order done");
      lanes = 2'h2;
      m_u.cyc(8'h56, 20'h11, 16'h5b5c);
      lanes = 2'h3;
      m_u.cyc(8'h56, 20'h11, 16'hffff);
      chk({pq, dq}, 18'h0a05c);
      $display("lane write done");
      end_sim();
   end
endmodule : testbench
